// ### rtl/spb_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of
//          the setpoint comparator and batching block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef SPB_DEFINES_SVH
`define SPB_DEFINES_SVH

// register byte offsets
`define SPB_CFG_OFS     8'h00
`define SPB_TGT1_OFS    8'h04
`define SPB_TGT2_OFS    8'h08
`define SPB_PRE1_OFS    8'h0C
`define SPB_PRE2_OFS    8'h10
`define SPB_SLOW1_OFS   8'h14
`define SPB_SLOW2_OFS   8'h18
`define SPB_UPPER_OFS   8'h1C
`define SPB_LOWER_OFS   8'h20
`define SPB_BAND_OFS    8'h24
`define SPB_CMD_OFS     8'h28
`define SPB_STAT_OFS    8'h2C

// configuration word fields
`define SPB_FN_LSB      0
`define SPB_SP1_LSB     3
`define SPB_SP2_LSB     6
`define SPB_SP1_POL     9
`define SPB_SP2_POL     10
`define SPB_LOW_POL     11
`define SPB_ACC_POL     12
`define SPB_HIGH_POL    13
`define SPB_OU_SEL      14
`define SPB_TMR1_LSB    16
`define SPB_TMR2_LSB    20
`define SPB_CFG_RST     24'h000000

// command word bits
`define SPB_CMD_START   0
`define SPB_CMD_CLEAR   1

// empty-scale band limits in graduations
`define SPB_BAND_MIN    6'h01
`define SPB_BAND_MAX    6'h32
`define SPB_BAND_RST    6'h01

// pause timer: 1 to 10 seconds, off = wait for start
`define SPB_TMR_MAX     4'hA
`define SPB_SECOND_NS   1000000000
`define SPB_CLK_NS      40

`endif

// ### rtl/spb_pkg.sv
// Purpose: types of the setpoint comparator and batching block
// Assumes: nothing beyond the defines header
// Notes:   enumerations carry no codes; software codes are decoded
package spb_pkg;

   // top-level function of the setpoint logic
   typedef enum logic [2:0] {
      FN_OFF, FN_SP, FN_OU, FN_MANUAL_BATCH_SELECT, FN_AUTO_BATCH_SELECT
   } spb_fn_t;

   // per-setpoint mode: A plain, B in-flight, C slow-feed, D both, E window
   typedef enum logic [2:0] {
      SPM_OFF, SPM_A, SPM_B, SPM_C, SPM_D, SPM_E
   } spb_mode_t;

   // batch sequencer
   typedef enum logic [3:0] {
      ST_IDLE, ST_TARE1, ST_FILL1, ST_PAUSE1,
      ST_TARE2, ST_FILL2, ST_PAUSE2
   } spb_state_t;

endpackage

// ### rtl/spb_setpoint.sv
// Purpose: setpoint comparator, over/under limits and batch sequencer
// Assumes: weight words are two's complement graduations; weight_valid
//          pulses once per new display value; keys are one-cycle pulses
// Notes:   outputs toward actuators are active low, lamps active high
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
`include "spb_defines.svh"

module spb_setpoint #(
   parameter int W = 24,
   parameter int unsigned TICKS_PER_SEC = `SPB_SECOND_NS / `SPB_CLK_NS
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [W-1:0] gross_weight,
   input wire logic weight_valid,
   input wire logic net_select,
   input wire logic tare_key,
   input wire logic start_key,
   input wire logic clear_key,
   input wire logic cfg_invalidate,
   output logic [2:0] setpoint_out_n,
   output logic [1:0] setpoint_lamp,
   output logic empty_scale,
   output logic cfg_error,
   output logic batch_active,
   output logic net_mode
);
   import spb_pkg::*;

   typedef struct packed {
      logic [23:0] cfg;
      logic signed [W-1:0] tgt1;
      logic signed [W-1:0] tgt2;
      logic signed [W-1:0] pre1;
      logic signed [W-1:0] pre2;
      logic signed [W-1:0] slow1;
      logic signed [W-1:0] slow2;
      logic signed [W-1:0] upper;
      logic signed [W-1:0] lower;
      logic [5:0] band;
      logic signed [W-1:0] tare;
      logic force_net;
      spb_state_t st;
      logic [31:0] tick;
      logic [3:0] secs;
      logic done1;
      logic done2;
      logic [2:0] act;
      logic band_hit;
      logic err;
      logic [31:0] rdata;
   } spb_regs_t;

   spb_regs_t r_reg;
   spb_regs_t r_next;

   localparam int X = W + 2;

   // widen before subtracting so offsets near full scale cannot wrap
   function automatic logic signed [X-1:0] ext(logic signed [W-1:0] v);
      return {{2{v[W-1]}}, v};
   endfunction

   // change point of a setpoint from its mode
   function automatic logic signed [X-1:0] point(spb_mode_t m,
         logic signed [W-1:0] sp, logic signed [W-1:0] pr,
         logic signed [W-1:0] sf);
      logic signed [X-1:0] p;
      p = ext(sp);
      unique case (m)
         SPM_B: p = ext(sp) - ext(pr);
         SPM_C: p = ext(sp) - ext(sf);
         SPM_D: p = ext(sp) - ext(sf) - ext(pr);
         default: p = ext(sp);
      endcase
      return p;
   endfunction

   // decode of software codes; unknown codes behave as off
   function automatic spb_mode_t mode_of(logic [2:0] c, logic allow_e);
      spb_mode_t m;
      unique case (c)
         3'h1: m = SPM_A;
         3'h2: m = SPM_B;
         3'h3: m = SPM_C;
         3'h4: m = SPM_D;
         3'h5: m = allow_e ? SPM_E : SPM_OFF;
         default: m = SPM_OFF;
      endcase
      return m;
   endfunction

   spb_fn_t fn;
   spb_mode_t m1;
   spb_mode_t m2;
   logic [3:0] tmr1;
   logic [3:0] tmr2;
   logic wr_en;
   logic rd_setup;
   logic addr_ok;
   logic start_ev;
   logic clear_ev;
   logic net_eff;
   logic signed [X-1:0] disp;
   logic signed [X-1:0] hi_lim;
   logic signed [X-1:0] lo_lim;
   logic signed [X-1:0] bandx;
   logic reach1;
   logic reach2;
   logic below;
   logic above;
   logic inr;
   logic cd_used;
   logic sec_tick;
   logic [2:0] straight;

   // configuration decode
   always_comb begin
      unique case (r_reg.cfg[`SPB_FN_LSB +: 3])
         3'h1: fn = FN_SP;
         3'h2: fn = FN_OU;
         3'h3: fn = FN_MANUAL_BATCH_SELECT;
         3'h4: fn = FN_AUTO_BATCH_SELECT;
         default: fn = FN_OFF;
      endcase
      m1 = mode_of(r_reg.cfg[`SPB_SP1_LSB +: 3], 1'b0);
      m2 = mode_of(r_reg.cfg[`SPB_SP2_LSB +: 3], fn == FN_SP);
      tmr1 = r_reg.cfg[`SPB_TMR1_LSB +: 4];
      tmr2 = r_reg.cfg[`SPB_TMR2_LSB +: 4];
   end

   // apb decode: zero wait states, read data caught in the setup cycle
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `SPB_STAT_OFS);
   assign wr_en = psel && penable && pwrite && addr_ok;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = r_reg.rdata;

   // start and clear arrive from keys or from the command register
   assign start_ev = start_key ||
      (wr_en && paddr == `SPB_CMD_OFS && pwdata[`SPB_CMD_START]);
   assign clear_ev = clear_key ||
      (wr_en && paddr == `SPB_CMD_OFS && pwdata[`SPB_CMD_CLEAR]);

   // displayed weight follows net selection and the held tare
   assign net_eff = net_select || r_reg.force_net;
   assign disp = net_eff ? ext(gross_weight) - ext(r_reg.tare)
                         : ext(gross_weight);

   // comparisons against the incoming display value
   always_comb begin
      reach1 = disp >= point(m1, r_reg.tgt1, r_reg.pre1, r_reg.slow1);
      reach2 = disp >= point(m2, r_reg.tgt2, r_reg.pre2, r_reg.slow2);
      // mode G centres the window on target 1, mode F uses it as is
      if (r_reg.cfg[`SPB_OU_SEL] && fn == FN_OU) begin
         hi_lim = ext(r_reg.tgt1) + ext(r_reg.upper);
         lo_lim = ext(r_reg.tgt1) - ext(r_reg.lower);
      end else begin
         hi_lim = ext(r_reg.upper);
         lo_lim = ext(r_reg.lower);
      end
      inr = (hi_lim > disp) && (disp > lo_lim);
      below = disp <= lo_lim;
      above = disp >= hi_lim;
      bandx = X'(r_reg.band);
      cd_used = (fn != FN_OFF && fn != FN_OU) &&
         (m1 == SPM_C || m1 == SPM_D || m2 == SPM_C || m2 == SPM_D);
   end

   // straight and over/under output levels, active high internally
   always_comb begin
      straight = 3'h0;
      if (fn == FN_SP) begin
         if (m1 != SPM_OFF)
            straight[0] = r_reg.cfg[`SPB_SP1_POL] ?
               !reach1 : reach1;
         if (m2 == SPM_E)
            straight[1] = r_reg.cfg[`SPB_SP2_POL] ? !inr : inr;
         else if (m2 != SPM_OFF)
            straight[1] = r_reg.cfg[`SPB_SP2_POL] ?
               !reach2 : reach2;
      end else if (fn == FN_OU) begin
         straight[0] = r_reg.cfg[`SPB_LOW_POL] ? below : !below;
         straight[1] = r_reg.cfg[`SPB_ACC_POL] ? inr : !inr;
         straight[2] = r_reg.cfg[`SPB_HIGH_POL] ? above : !above;
      end
   end

   assign sec_tick = r_reg.tick == TICKS_PER_SEC - 1;

   // next state of the whole block
   always_comb begin
      r_next = r_reg;
      r_next.rdata = 32'h00000000;

      // register writes take effect in the access cycle
      if (wr_en) begin
         unique case (paddr)
            `SPB_CFG_OFS: r_next.cfg = pwdata[23:0];
            `SPB_TGT1_OFS: r_next.tgt1 = pwdata[W-1:0];
            `SPB_TGT2_OFS: r_next.tgt2 = pwdata[W-1:0];
            `SPB_PRE1_OFS: r_next.pre1 = pwdata[W-1:0];
            `SPB_PRE2_OFS: r_next.pre2 = pwdata[W-1:0];
            `SPB_SLOW1_OFS: r_next.slow1 = pwdata[W-1:0];
            `SPB_SLOW2_OFS: r_next.slow2 = pwdata[W-1:0];
            `SPB_UPPER_OFS: r_next.upper = pwdata[W-1:0];
            `SPB_LOWER_OFS: r_next.lower = pwdata[W-1:0];
            `SPB_BAND_OFS: begin
               // out-of-range widths clamp into 1..50
               if (pwdata[31:6] != 26'h0 || pwdata[5:0] > `SPB_BAND_MAX)
                  r_next.band = `SPB_BAND_MAX;
               else if (pwdata[5:0] < `SPB_BAND_MIN)
                  r_next.band = `SPB_BAND_MIN;
               else
                  r_next.band = pwdata[5:0];
            end
            default: ;
         endcase
      end

      // error sticks until config is rewritten; a new fault wins
      if (wr_en && paddr == `SPB_CFG_OFS)
         r_next.err = 1'b0;
      if (cfg_invalidate)
         r_next.err = 1'b1;

      // read data registered in the setup cycle
      if (rd_setup) begin
         unique case (paddr)
            `SPB_CFG_OFS: r_next.rdata = {8'h00, r_reg.cfg};
            `SPB_TGT1_OFS: r_next.rdata = 32'(r_reg.tgt1);
            `SPB_TGT2_OFS: r_next.rdata = 32'(r_reg.tgt2);
            `SPB_PRE1_OFS: r_next.rdata = 32'(r_reg.pre1);
            `SPB_PRE2_OFS: r_next.rdata = 32'(r_reg.pre2);
            `SPB_SLOW1_OFS: r_next.rdata = 32'(r_reg.slow1);
            `SPB_SLOW2_OFS: r_next.rdata = 32'(r_reg.slow2);
            `SPB_UPPER_OFS: r_next.rdata = 32'(r_reg.upper);
            `SPB_LOWER_OFS: r_next.rdata = 32'(r_reg.lower);
            `SPB_BAND_OFS: r_next.rdata = {26'h0, r_reg.band};
            `SPB_STAT_OFS: r_next.rdata = {20'h0, r_reg.st, 1'b0,
               net_eff, r_reg.st != ST_IDLE, r_reg.err, r_reg.band_hit,
               r_reg.act};
            default: r_next.rdata = 32'h00000000;
         endcase
      end

      // manual tare key outside a running batch
      if (tare_key && r_reg.st == ST_IDLE)
         r_next.tare = gross_weight;

      // pause second counter runs only in a timed pause
      if ((r_reg.st == ST_PAUSE1 || r_reg.st == ST_PAUSE2) &&
          r_reg.secs != 4'h0)
         r_next.tick = sec_tick ? 32'h0 : r_reg.tick + 32'h1;
      else
         r_next.tick = 32'h0;

      // batch sequencer
      unique case (r_reg.st)
         ST_IDLE: begin
            if (start_ev && (fn == FN_MANUAL_BATCH_SELECT || fn == FN_AUTO_BATCH_SELECT)) begin
               r_next.done1 = 1'b0;
               r_next.done2 = 1'b0;
               r_next.st = (fn == FN_AUTO_BATCH_SELECT) ? ST_TARE1 : ST_FILL1;
               r_next.force_net = fn == FN_AUTO_BATCH_SELECT;
            end
         end
         ST_TARE1: begin
            r_next.tare = gross_weight;
            r_next.st = ST_FILL1;
         end
         ST_FILL1: begin
            // a disabled setpoint passes straight on to the pause
            if (m1 == SPM_OFF || (weight_valid && reach1)) begin
               r_next.done1 = 1'b1;
               r_next.st = ST_PAUSE1;
               r_next.secs = (fn == FN_AUTO_BATCH_SELECT) ? tmr1 : 4'h0;
               if (r_next.secs > `SPB_TMR_MAX)
                  r_next.secs = `SPB_TMR_MAX;
            end
         end
         ST_PAUSE1: begin
            if (start_ev || (r_reg.secs == 4'h1 && sec_tick)) begin
               r_next.st = (fn == FN_AUTO_BATCH_SELECT) ? ST_TARE2 : ST_FILL2;
               r_next.secs = 4'h0;
            end else if (sec_tick) begin
               r_next.secs = r_reg.secs - 4'h1;
            end
         end
         ST_TARE2: begin
            r_next.tare = gross_weight;
            r_next.st = ST_FILL2;
         end
         ST_FILL2: begin
            if (m2 == SPM_OFF || (weight_valid && reach2)) begin
               r_next.done2 = 1'b1;
               r_next.st = ST_PAUSE2;
               r_next.secs = (fn == FN_AUTO_BATCH_SELECT) ? tmr2 : 4'h0;
               if (r_next.secs > `SPB_TMR_MAX)
                  r_next.secs = `SPB_TMR_MAX;
            end
         end
         ST_PAUSE2: begin
            if (start_ev || (r_reg.secs == 4'h1 && sec_tick)) begin
               r_next.st = ST_IDLE;
               r_next.force_net = 1'b0;
               r_next.secs = 4'h0;
            end else if (sec_tick) begin
               r_next.secs = r_reg.secs - 4'h1;
            end
         end
      endcase

      // clear aborts any batch; a change to a non-batch function also ends it
      if (clear_ev || (r_reg.st != ST_IDLE &&
          fn != FN_MANUAL_BATCH_SELECT && fn != FN_AUTO_BATCH_SELECT)) begin
         r_next.st = ST_IDLE;
         r_next.force_net = 1'b0;
         r_next.secs = 4'h0;
      end

      // outputs move only on a new display value or a sequencer step, or clear at once with the function off or switched to batching
      if (fn == FN_MANUAL_BATCH_SELECT || fn == FN_AUTO_BATCH_SELECT) begin
         r_next.act = 3'h0;
         r_next.act[0] = r_next.st == ST_FILL1 && !r_next.done1
            && m1 != SPM_OFF;
         r_next.act[1] = r_next.st == ST_FILL2 && !r_next.done2
            && m2 != SPM_OFF;
      end else if (fn == FN_OFF) begin
         r_next.act = 3'h0;
      end else if (weight_valid) begin
         r_next.act = straight;
      end

      // empty-scale band, kept alive even with setpoints off
      if (cd_used)
         r_next.band_hit = 1'b0;
      else if (weight_valid)
         r_next.band_hit = (disp < bandx) && (disp > -bandx);
   end

   // state register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
         r_reg.cfg <= `SPB_CFG_RST;
         r_reg.band <= `SPB_BAND_RST;
         r_reg.st <= ST_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   // pins: sinking outputs, lamps follow the lines
   assign setpoint_out_n = ~r_reg.act;
   assign setpoint_lamp = r_reg.act[1:0];
   assign empty_scale = r_reg.band_hit;
   assign cfg_error = r_reg.err;
   assign batch_active = r_reg.st != ST_IDLE;
   assign net_mode = r_reg.force_net;

endmodule

// ### tb/spb_field.sv
// Purpose: field side of the setpoint lines: valves, relays, lamps
// Assumes: sinking outputs with pull-ups, lamps lit when high
// Notes:   valve_on is what a coil on each line would see
`timescale 1ns/10ps
module spb_field (
   input wire logic [2:0] setpoint_out_n,
   input wire logic [1:0] setpoint_lamp,
   output logic [2:0] valve_on,
   output logic [1:0] lamp_lit
);
   // a low line sinks coil current; high is the pull-up, coil idle
   assign valve_on = ~setpoint_out_n;
   // lamps only indicate, they load nothing back onto the block
   assign lamp_lit = setpoint_lamp;
endmodule

// ### tb/spb_setpoint_assertions.sv
// Purpose: port-level checks of the setpoint block
// Assumes: function field shadowed from apb writes to offset 0
// Notes:   bound to every spb_setpoint instance
`timescale 1ns/10ps
module spb_setpoint_chk (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic weight_valid,
   input wire logic start_key,
   input wire logic clear_key,
   input wire logic cfg_invalidate,
   input wire logic [2:0] setpoint_out_n,
   input wire logic [1:0] setpoint_lamp,
   input wire logic empty_scale,
   input wire logic cfg_error,
   input wire logic batch_active,
   input wire logic net_mode
);
   logic [2:0] fn_reg;
   logic wr, fb, fo;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   // the checker cannot see the config, so it keeps its own copy
   assign wr = psel && penable && pwrite;
   assign fb = fn_reg == 3'h3 || fn_reg == 3'h4;
   assign fo = fn_reg == 3'h0 || fn_reg > 3'h4;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) fn_reg <= 3'h0;
      else if (wr && paddr == 8'h00) fn_reg <= pwdata[2:0];
   end
   a_lamp_mirror: assert property (
      setpoint_lamp == ~setpoint_out_n[1:0])
      else $error("lamp differs from its output line");
   a_off_quiet: assert property (
      fo && weight_valid |=> setpoint_out_n == 3'h7)
      else $error("output active with function off");
   a_batch_idle: assert property (
      fb && !batch_active && !start_key && weight_valid
      |=> setpoint_out_n == 3'h7)
      else $error("output active outside a batch");
   a_clear_abort: assert property (
      clear_key && batch_active |=> !batch_active && setpoint_out_n == 3'h7)
      else $error("clear did not abort the batch");
   a_start_runs: assert property (
      fb && !batch_active && start_key && !clear_key |=> batch_active)
      else $error("start did not begin a batch");
   a_auto_net: assert property (
      fn_reg == 3'h4 && !batch_active && start_key && !clear_key
      |-> ##[1:2] net_mode)
      else $error("auto batch did not go net");
   a_latch_hold: assert property (
      batch_active && $rose(setpoint_out_n[0]) |=> setpoint_out_n[0] [*4])
      else $error("cut off output came back");
   a_band_hold: assert property (
      !weight_valid && !wr && !$past(wr) |=> $stable(empty_scale))
      else $error("band flag moved without new weight");
   a_error_set: assert property (
      cfg_invalidate |=> cfg_error)
      else $error("invalid setup not flagged");
endmodule

bind spb_setpoint spb_setpoint_chk i_chk (.mclk, .resetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .weight_valid, .start_key,
   .clear_key, .cfg_invalidate, .setpoint_out_n, .setpoint_lamp,
   .empty_scale, .cfg_error, .batch_active, .net_mode);

// ### tb/tb_top.sv
// Purpose: self-checking bench of the setpoint block
// Assumes: one second cut to ten clocks through TICKS_PER_SEC
// Notes:   the apb master holds every request until pready
`timescale 1ns/10ps
module tb_top;
   import spb_pkg::*;
   logic mclk, resetn, psel, penable, pwrite, pready, pslverr, perr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [23:0] gross_weight;
   logic weight_valid, net_select, tare_key, start_key, clear_key;
   logic cfg_invalidate, empty_scale, cfg_error, batch_active, net_mode;
   logic [2:0] setpoint_out_n, valve_on;
   logic [1:0] setpoint_lamp, lamp_lit;
   int miscompares, check_count;

   spb_setpoint #(.W(24), .TICKS_PER_SEC(10)) i_dut (
      .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .gross_weight, .weight_valid, .net_select,
      .tare_key, .start_key, .clear_key, .cfg_invalidate, .setpoint_out_n,
      .setpoint_lamp, .empty_scale, .cfg_error, .batch_active, .net_mode);
   spb_field i_field (.setpoint_out_n, .setpoint_lamp, .valve_on, .lamp_lit);

   // 25 MHz clock
   always #20 mclk = ~mclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; result left in rd and perr, sampled settled
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge mclk);
   endtask

   // present one new display value, then let the registered answer land
   task automatic wt(input int w);
      @(posedge mclk);
      gross_weight <= 24'(w);
      weight_valid <= 1'b1;
      @(posedge mclk);
      weight_valid <= 1'b0;
      @(negedge mclk);
   endtask

   // 0 start, 1 clear, 2 setup invalidated, 3 tare
   task automatic key(input int k);
      @(posedge mclk);
      if (k == 0) start_key <= 1'b1;
      else if (k == 1) clear_key <= 1'b1;
      else if (k == 2) cfg_invalidate <= 1'b1;
      else tare_key <= 1'b1;
      @(posedge mclk);
      start_key <= 1'b0;
      clear_key <= 1'b0;
      cfg_invalidate <= 1'b0;
      tare_key <= 1'b0;
      @(negedge mclk);
   endtask

   // e is the expected line pattern; lamps and coils follow from it
   task automatic out(input logic [2:0] e);
      chk(setpoint_out_n, e);
      chk(lamp_lit, {30'h0, ~e[1:0]});
      chk(valve_on, {29'h0, ~e});
   endtask

   function automatic logic [31:0] cfg(input logic [2:0] fn,
      input logic [2:0] m1, input logic [2:0] m2, input logic [5:0] pg,
      input logic [7:0] t);
      return {8'h00, t, 1'b0, pg, m2, m1, fn};
   endfunction

   task automatic t_reset;
      out(3'h7);
      chk(cfg_error, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'h1);
   endtask

   task automatic t_band;
      apb(1'b1, 8'h24, 32'h3);
      wt(-2);
      chk(empty_scale, 32'h1);
      wt(-3);
      chk(empty_scale, 32'h0);
      wt(500);
      out(3'h7);
      apb(1'b1, 8'h24, 32'h3C);
      wt(49);
      chk(empty_scale, 32'h1);
      wt(50);
      chk(empty_scale, 32'h0);
   endtask

   task automatic t_straight;
      apb(1'b1, 8'h04, 32'h64);
      apb(1'b1, 8'h08, 32'hC8);
      apb(1'b1, 8'h0C, 32'h5);
      apb(1'b1, 8'h10, 32'hA);
      apb(1'b1, 8'h14, 32'h14);
      apb(1'b1, 8'h1C, 32'h96);
      apb(1'b1, 8'h20, 32'h32);
      apb(1'b1, 8'h00, cfg(3'h1, 3'h1, 3'h2, 6'h00, 8'h00));
      wt(99);
      out(3'h7);
      wt(100);
      out(3'h6);
      wt(189);
      out(3'h6);
      wt(190);
      out(3'h4);
      wt(40);
      key(3);
      @(posedge mclk);
      net_select <= 1'b1;
      wt(139);
      out(3'h7);
      wt(140);
      out(3'h6);
      @(posedge mclk);
      net_select <= 1'b0;
      apb(1'b1, 8'h00, cfg(3'h1, 3'h4, 3'h5, 6'h01, 8'h00));
      wt(74);
      out(3'h4);
      wt(75);
      out(3'h5);
      wt(150);
      out(3'h7);
      wt(0);
      out(3'h6);
      chk(empty_scale, 32'h0);
   endtask

   task automatic t_ou;
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, 8'h00, cfg(3'h2, 3'h0, 3'h0, p ? 6'h1F : 6'h00, 8'h00));
         wt(50);
         out(p ? 3'h6 : 3'h1);
         wt(100);
         out(p ? 3'h5 : 3'h2);
         wt(150);
         out(p ? 3'h3 : 3'h4);
      end
      apb(1'b1, 8'h1C, 32'h14);
      apb(1'b1, 8'h20, 32'h14);
      apb(1'b1, 8'h00, cfg(3'h2, 3'h0, 3'h0, 6'h20, 8'h00));
      wt(81);
      out(3'h2);
      wt(80);
      out(3'h1);
      wt(120);
      out(3'h4);
   endtask

   task automatic t_manual;
      apb(1'b1, 8'h00, cfg(3'h3, 3'h1, 3'h1, 6'h00, 8'h00));
      wt(150);
      out(3'h7);
      key(0);
      chk(batch_active, 32'h1);
      wt(99);
      out(3'h6);
      wt(100);
      out(3'h7);
      wt(0);
      out(3'h7);
      key(0);
      out(3'h5);
      wt(200);
      out(3'h7);
      key(0);
      chk(batch_active, 32'h0);
      key(0);
      key(1);
      out(3'h7);
      chk(batch_active, 32'h0);
      // start and clear also arrive through the command register
      apb(1'b1, 8'h28, 32'h1);
      chk(batch_active, 32'h1);
      out(3'h6);
      apb(1'b1, 8'h28, 32'h2);
      chk(batch_active, 32'h0);
      out(3'h7);
   endtask

   task automatic t_auto;
      apb(1'b1, 8'h00, cfg(3'h4, 3'h1, 3'h1, 6'h00, 8'h01));
      wt(30);
      key(0);
      @(negedge mclk);
      chk(net_mode, 32'h1);
      wt(129);
      out(3'h6);
      wt(130);
      out(3'h7);
      repeat (5) @(negedge mclk);
      out(3'h7);
      repeat (10) @(negedge mclk);
      out(3'h5);
      wt(330);
      out(3'h7);
      repeat (30) @(negedge mclk);
      chk(batch_active, 32'h1);
      key(0);
      chk(net_mode, 32'h0);
   endtask

   task automatic t_errors;
      key(2);
      chk(cfg_error, 32'h1);
      apb(1'b1, 8'h24, 32'h5);
      chk(cfg_error, 32'h1);
      apb(1'b1, 8'h00, 32'h0);
      chk(cfg_error, 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      chk({perr, rd[30:0]}, 32'h80000000);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h64);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // the run needs about 230 clocks; this is ample margin
   initial begin
      #400000;
      miscompares++;
      tally_and_finish;
   end

   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      {psel, penable, pwrite, weight_valid, net_select} = 5'h0;
      {tare_key, start_key, clear_key, cfg_invalidate} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      gross_weight = 24'h0;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      @(negedge mclk);
      t_reset;
      t_band;
      t_straight;
      t_ou;
      t_manual;
      t_auto;
      t_errors;
      tally_and_finish;
   end
endmodule
